//--- common/fbsi_pkg.sv
// Package of constants and types for the fieldbus slave status indication.
// Overview of operation
// - Read own data, insert data, forward frame.
// - Last node returns frame when port open.
// - SM0/1 mailbox out/in, SM2/3 process data.
// - FMMU0 outputs, FMMU1 inputs, FMMU2 mailbox status.
// - Execute the ten listed data-link commands.
// - Mailbox: emergency, SDO request and response only.
// - Free-run, distributed clock, or SM2 event sync.
// - Clock cycle 125 us to 8 ms, 125 us steps.
// - Run indicator dark in initial state.
// - Run blinks pre-op, single flash safe-op.
// - Run indicator steady in operational state.
// - Error dark; blinks on refused state change.
// - Sync error single flash; watchdog double flash.
// - Boot error flickers; interface watchdog steady lit.
// - Link/activity: dark, steady, or flicker on traffic.
// - States advance on master request; a sync error drops op to safe-op.
package fbsi_pkg;
    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_HZ = 125_000_000;
    localparam int SLOW_PHASE_MS = 200;
    localparam int FAST_PHASE_MS = 50;
    localparam int TICK_MS = 50;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int SLOW_TICKS = SLOW_PHASE_MS / TICK_MS;
    localparam int FAST_TICKS = FAST_PHASE_MS / TICK_MS;
    // Single flash: one phase on, then five phases dark.
    localparam int SINGLE_LEN = 6;
    // Double flash: on, off, on, then five phases dark.
    localparam int DOUBLE_LEN = 8;
    localparam int DC_STEP_US = 125;
    localparam int DC_MAX_US = 8000;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [1:0] {
        FBSI_ST_INIT = 2'b00,
        FBSI_ST_PREOP = 2'b01,
        FBSI_ST_SAFEOP = 2'b10,
        FBSI_ST_OP = 2'b11
    } fbsi_state_t;

    typedef enum logic [2:0] {
        FBSI_PAT_OFF = 3'b000,
        FBSI_PAT_ON = 3'b001,
        FBSI_PAT_BLINK = 3'b010,
        FBSI_PAT_SINGLE = 3'b011,
        FBSI_PAT_DOUBLE = 3'b100,
        FBSI_PAT_FLICKER = 3'b101
    } fbsi_pat_t;

    typedef struct packed {
        logic refused;
        logic sync_err;
        logic sm_wdog;
        logic boot_err;
        logic pdi_wdog;
    } fbsi_err_t;

    // Byte of a passing frame with its last-byte flag.
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } fbsi_word_t;
endpackage : fbsi_pkg

//--- src/fbsi_pattern.sv
// Indicator pattern generator for one lamp.
`timescale 1ns/1ps
module fbsi_pattern (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Timing and selection
    input wire logic tick,
    input wire fbsi_pkg::fbsi_pat_t pat,
    // Lamp
    output logic lamp
);
    import fbsi_pkg::*;

    fbsi_pat_t pat_q;
    logic [3:0] phase_q;
    logic [3:0] sub_q;
    logic [3:0] len;
    logic [3:0] step;

    always_comb begin
        len = 4'h2;
        step = 4'(SLOW_TICKS);
        unique case (pat)
            FBSI_PAT_SINGLE: len = 4'(SINGLE_LEN);
            FBSI_PAT_DOUBLE: len = 4'(DOUBLE_LEN);
            FBSI_PAT_FLICKER: step = 4'(FAST_TICKS);
            default: len = 4'h2;
        endcase
    end

    // A change of pattern restarts at the first lit phase.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pat_q <= FBSI_PAT_OFF;
            phase_q <= 4'h0;
            sub_q <= 4'h0;
        end else if (pat != pat_q) begin
            pat_q <= pat;
            phase_q <= 4'h0;
            sub_q <= 4'h0;
        end else if (tick) begin
            if (sub_q == step - 4'h1) begin
                sub_q <= 4'h0;
                phase_q <= (phase_q == len - 4'h1) ? 4'h0 : phase_q + 4'h1;
            end else begin
                sub_q <= sub_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lamp <= 1'b0;
        end else begin
            unique case (pat_q)
                FBSI_PAT_OFF: lamp <= 1'b0;
                FBSI_PAT_ON: lamp <= 1'b1;
                FBSI_PAT_BLINK, FBSI_PAT_FLICKER: lamp <= ~phase_q[0];
                FBSI_PAT_SINGLE: lamp <= (phase_q == 4'h0);
                FBSI_PAT_DOUBLE: lamp <= (phase_q == 4'h0) ||
                                         (phase_q == 4'h2);
                default: lamp <= 1'b0;
            endcase
        end
    end
endmodule : fbsi_pattern

//--- src/fbsi_top.sv
// Frame pass-through, state tracking and status lamps of the slave.
`timescale 1ns/1ps
module fbsi_top #(
    parameter int TICK_CYCLES_P = fbsi_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Upstream frame bytes
    input wire fbsi_pkg::fbsi_word_t RX_WORD,
    input wire logic RX_VALID,
    output logic RX_READY,
    // Downstream frame bytes
    output fbsi_pkg::fbsi_word_t TX_WORD,
    output logic TX_VALID,
    input wire logic TX_READY,
    // Return path when the outgoing port is open
    output fbsi_pkg::fbsi_word_t RET_WORD,
    output logic RET_VALID,
    input wire logic RET_READY,
    // Bytes addressed to this slave and bytes it inserts
    input wire logic ADDR_HIT,
    input wire logic [7:0] INSERT_DATA,
    input wire logic INSERT_EN,
    output logic [7:0] READ_DATA,
    output logic READ_STB,
    // Command and mailbox service codes
    input wire logic [7:0] CMD_CODE,
    output logic CMD_OK,
    input wire logic [3:0] MBX_SERVICE,
    output logic MBX_OK,
    // Sync manager and mapping unit roles
    output logic [1:0] SM_ROLE [4],
    output logic [1:0] FMMU_ROLE [3],
    // Synchronisation configuration
    input wire logic [1:0] SYNC_MODE_REQ,
    input wire logic [15:0] DC_CYCLE_US,
    output logic [1:0] SYNC_MODE,
    output logic DC_CYCLE_BAD,
    // Communication state and errors
    input wire fbsi_pkg::fbsi_state_t STATE_REQ,
    input wire logic STATE_REQ_STB,
    input wire fbsi_pkg::fbsi_err_t ERR_IN,
    input wire logic ERR_CLEAR,
    output fbsi_pkg::fbsi_state_t STATE,
    output logic OUT_PD_EN,
    output logic IN_PD_EN,
    // Port pins
    input wire logic [1:0] LINK_PIN,
    input wire logic [1:0] ACT_PIN,
    // Lamps
    output logic RUN_LED,
    output logic ERR_LED,
    output logic [1:0] LINK_LED
);
    import fbsi_pkg::*;

    // ********************************************************
    // Roles of sync managers and mapping units
    // ********************************************************
    // Role codes: 0 mailbox out, 1 mailbox in, 2 pd out, 3 pd in.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            SM_ROLE[i] = 2'(i);
        end
    end
    // Mapping roles: 0 pd out area, 1 pd in area, 2 mailbox status.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            FMMU_ROLE[i] = 2'(i);
        end
    end

    // ********************************************************
    // Command and mailbox acceptance
    // ********************************************************
    function automatic logic cmd_known(input logic [7:0] c);
        // Codes of APRD..FRMW families; NOP and RW variants refused.
        unique case (c)
            8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08,
            8'h0a, 8'h0b, 8'h0d, 8'h0e: cmd_known = 1'b1;
            default: cmd_known = 1'b0;
        endcase
    endfunction : cmd_known

    assign CMD_OK = cmd_known(CMD_CODE);
    // Services 1 emergency, 2 SDO request, 3 SDO response.
    assign MBX_OK = (MBX_SERVICE >= 4'h1) &&
                    (MBX_SERVICE <= 4'h3);

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    // Only the second stage is read, so no logic sees a pin that may
    // still be settling.
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
        end else begin
            pin_s1_q <= {ACT_PIN, LINK_PIN};
            pin_s2_q <= pin_s1_q;
        end
    end

    // ********************************************************
    // Frame path
    // ********************************************************
    // Bytes pass through the buffer, addressed ones replaced by INSERT_DATA when INSERT_EN; only a pipeline stage of
    // delay is added, and the buffer keeps a stall from dropping bytes.
    fbsi_word_t fwd_word;
    logic fwd_valid;
    logic fwd_ready;
    logic port_open;
    logic rd_stb_q;
    logic [7:0] rd_data_q;

    assign port_open = ~pin_s2_q[1];
    always_comb begin
        fwd_word = RX_WORD;
        if (ADDR_HIT && INSERT_EN) begin
            fwd_word.data = INSERT_DATA;
        end
    end
    assign fwd_valid = RX_VALID;
    assign RX_READY = fwd_ready;

    // The strobe stands in the cycle after an addressed byte was taken,
    // and the data register shows that byte in the same cycle.

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rd_stb_q <= 1'b0;
            rd_data_q <= 8'h00;
        end else begin
            rd_stb_q <= RX_VALID && fwd_ready && ADDR_HIT;
            rd_data_q <= RX_WORD.data;
        end
    end
    assign READ_STB = rd_stb_q;
    assign READ_DATA = rd_data_q;

    // Two-entry buffer. Outputs come straight from the entry registers,
    // so a stalled word stands unchanged until it is taken.
    fbsi_word_t buf_q [2];
    logic [1:0] cnt_q;
    logic rd_ptr_q;
    logic wr_ptr_q;
    logic out_ready;
    logic push;
    logic pop;

    assign fwd_ready = (cnt_q != 2'h2);
    assign push = fwd_valid && fwd_ready;
    // Last node sends the frame back on the return path.
    assign out_ready = port_open ? RET_READY : TX_READY;
    assign pop = (cnt_q != 2'h0) && out_ready;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            cnt_q <= 2'h0;
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else begin
            if (push) begin
                buf_q[wr_ptr_q] <= fwd_word;
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            cnt_q <= cnt_q + 2'(push) - 2'(pop);
        end
    end

    assign TX_WORD = buf_q[rd_ptr_q];
    assign RET_WORD = buf_q[rd_ptr_q];
    assign TX_VALID = (cnt_q != 2'h0) && !port_open;
    assign RET_VALID = (cnt_q != 2'h0) && port_open;

    // ********************************************************
    // Synchronisation mode and cycle check
    // ********************************************************
    logic [1:0] sync_mode_q;
    logic dc_bad;
    always_comb begin
        dc_bad = (DC_CYCLE_US < 16'(DC_STEP_US)) ||
                 (DC_CYCLE_US > 16'(DC_MAX_US)) ||
                 ((DC_CYCLE_US % 16'(DC_STEP_US)) != 16'h0000);
    end
    // A DC request with an illegal cycle, or the unused mode 3, is
    // ignored: the slave keeps its last mode; a cycle that turns illegal
    // while already in DC mode only raises DC_CYCLE_BAD.
    logic mode_take;
    assign mode_take = (SYNC_MODE_REQ != 2'h3) &&
                       !(SYNC_MODE_REQ == 2'h1 && dc_bad);
    // Mode 0 free run, 1 distributed clock, 2 SM2 event.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sync_mode_q <= 2'h0;
        end else if (mode_take) begin
            sync_mode_q <= SYNC_MODE_REQ;
        end
    end
    assign SYNC_MODE = sync_mode_q;
    // The flag only matters in DC mode; other modes ignore the cycle.
    assign DC_CYCLE_BAD = (sync_mode_q == 2'h1) && dc_bad;

    // ********************************************************
    // Communication state
    // ********************************************************
    // A sync error in operational state outranks a request: outputs must stop at once rather
    // than follow a command that is already stale.
    fbsi_state_t state_q;
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_q <= FBSI_ST_INIT;
        end else if (ERR_IN.sync_err && state_q == FBSI_ST_OP) begin
            state_q <= FBSI_ST_SAFEOP;
        end else if (STATE_REQ_STB && !ERR_IN.refused) begin
            state_q <= STATE_REQ;
        end
    end
    assign STATE = state_q;
    // Safe-operational passes inputs only; outputs wait for operational.
    assign IN_PD_EN = (state_q == FBSI_ST_SAFEOP) ||
                      (state_q == FBSI_ST_OP);
    assign OUT_PD_EN = (state_q == FBSI_ST_OP);

    // ********************************************************
    // Sticky error flags
    // ********************************************************
    // A clear loads the present inputs, so an error that recurs in the
    // clearing cycle survives it and no event is lost.
    fbsi_err_t err_q;
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            err_q <= '0;
        end else if (ERR_CLEAR) begin
            err_q <= ERR_IN;
        end else begin
            err_q <= err_q | ERR_IN;
        end
    end

    // ********************************************************
    // Tick and lamps
    // ********************************************************
    // One shared tick keeps all lamps in step and builds the divider
    // once; each generator counts ticks into phases itself.
    logic [31:0] tick_cnt_q;
    logic tick_q;
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 32'(TICK_CYCLES_P - 1)) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    fbsi_pat_t run_pat;
    fbsi_pat_t err_pat;
    fbsi_pat_t link_pat [2];

    always_comb begin
        unique case (state_q)
            FBSI_ST_INIT: run_pat = FBSI_PAT_OFF;
            FBSI_ST_PREOP: run_pat = FBSI_PAT_BLINK;
            FBSI_ST_SAFEOP: run_pat = FBSI_PAT_SINGLE;
            FBSI_ST_OP: run_pat = FBSI_PAT_ON;
        endcase
    end

    // Worst error wins the single lamp.
    always_comb begin
        if (err_q.pdi_wdog) begin
            err_pat = FBSI_PAT_ON;
        end else if (err_q.boot_err) begin
            err_pat = FBSI_PAT_FLICKER;
        end else if (err_q.sm_wdog) begin
            err_pat = FBSI_PAT_DOUBLE;
        end else if (err_q.sync_err) begin
            err_pat = FBSI_PAT_SINGLE;
        end else if (err_q.refused) begin
            err_pat = FBSI_PAT_BLINK;
        end else begin
            err_pat = FBSI_PAT_OFF;
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            // A lost link outranks activity, as no traffic passes then.
            if (!pin_s2_q[i]) begin
                link_pat[i] = FBSI_PAT_OFF;
            end else if (pin_s2_q[2 + i]) begin
                link_pat[i] = FBSI_PAT_FLICKER;
            end else begin
                link_pat[i] = FBSI_PAT_ON;
            end
        end
    end

    fbsi_pattern u_run (
        .clk(SYS_CLK),
        .rst(RST),
        .tick(tick_q),
        .pat(run_pat),
        .lamp(RUN_LED)
    );

    fbsi_pattern u_err (
        .clk(SYS_CLK),
        .rst(RST),
        .tick(tick_q),
        .pat(err_pat),
        .lamp(ERR_LED)
    );

    for (genvar g = 0; g < 2; g++) begin : g_link
        fbsi_pattern u_link (
            .clk(SYS_CLK),
            .rst(RST),
            .tick(tick_q),
            .pat(link_pat[g]),
            .lamp(LINK_LED[g])
        );
    end
endmodule : fbsi_top

//--- testbench/fbsi_master_model.sv
// Behavioural master side that takes the stream with random stalls.
`timescale 1ns/1ps
module fbsi_master_model (
    // Clock
    input wire logic clk,
    // Stream from the slave
    input wire logic valid,
    input wire fbsi_pkg::fbsi_word_t word,
    input wire logic stall,
    output logic ready,
    output logic got,
    output fbsi_pkg::fbsi_word_t got_w
);
    import fbsi_pkg::*;
    initial begin
        ready = 1'b0;
        got = 1'b0;
        got_w = '0;
    end
    // Ready is redrawn each cycle, so the slave must hold its word.
    always @(negedge clk) begin
        ready = !stall && ($urandom_range(3) != 0);
        got = valid && ready;
        got_w = word;
    end
endmodule : fbsi_master_model

//--- testbench/fbsi_top_assertions.sv
// Port checker of the slave status block, bound into its top module.
`timescale 1ns/1ps
module fbsi_top_checker (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Frame stream
    input wire logic RX_VALID,
    input wire logic RX_READY,
    input wire logic ADDR_HIT,
    input wire logic READ_STB,
    input wire fbsi_pkg::fbsi_word_t TX_WORD,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic RET_VALID,
    input wire logic RET_READY,
    // Codes and configuration
    input wire logic [7:0] CMD_CODE,
    input wire logic CMD_OK,
    input wire logic [3:0] MBX_SERVICE,
    input wire logic MBX_OK,
    input wire logic [15:0] DC_CYCLE_US,
    input wire logic DC_CYCLE_BAD,
    input wire logic [1:0] SYNC_MODE,
    // State, errors and lamps
    input wire fbsi_pkg::fbsi_state_t STATE_REQ,
    input wire logic STATE_REQ_STB,
    input wire fbsi_pkg::fbsi_err_t ERR_IN,
    input wire fbsi_pkg::fbsi_state_t STATE,
    input wire logic OUT_PD_EN,
    input wire logic IN_PD_EN,
    input wire logic [1:0] LINK_PIN,
    input wire logic [1:0] ACT_PIN,
    input wire logic RUN_LED,
    input wire logic ERR_LED,
    input wire logic [1:0] LINK_LED
);
    import fbsi_pkg::*;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    cmd_table_a: assert property (
        CMD_OK == (CMD_CODE inside {8'h01, 8'h02, 8'h04, 8'h05, 8'h07,
        8'h08, 8'h0a, 8'h0b, 8'h0d, 8'h0e}))
        else $error("command accept flag wrong");
    mbx_service_a: assert property (
        MBX_OK == (MBX_SERVICE inside {1, 2, 3}))
        else $error("mailbox service flag wrong");
    dc_range_a: assert property (
        DC_CYCLE_BAD == (SYNC_MODE == 2'h1 && !(DC_CYCLE_US >= DC_STEP_US &&
        DC_CYCLE_US <= DC_MAX_US && DC_CYCLE_US % DC_STEP_US == 0)))
        else $error("cycle range flag wrong");
    stream_hold_a: assert property (
        TX_VALID && !TX_READY && LINK_PIN[1] |=>
        TX_VALID && $stable(TX_WORD)) else $error("word not held");
    read_strobe_a: assert property (RX_VALID && RX_READY
        |=> READ_STB == $past(ADDR_HIT)) else $error("read strobe wrong");
    state_take_a: assert property (
        STATE_REQ_STB && !ERR_IN.refused && !ERR_IN.sync_err
        |=> STATE == $past(STATE_REQ)) else $error("state request not taken");
    refused_hold_a: assert property (
        STATE_REQ_STB && ERR_IN.refused && !ERR_IN.sync_err
        |=> $stable(STATE)) else $error("refused change made");
    sync_fall_a: assert property (
        ERR_IN.sync_err && STATE == FBSI_ST_OP |=> STATE == FBSI_ST_SAFEOP)
        else $error("no fall to safe state");
    pd_dir_a: assert property (
        OUT_PD_EN == (STATE == FBSI_ST_OP) &&
        IN_PD_EN == (STATE == FBSI_ST_OP || STATE == FBSI_ST_SAFEOP))
        else $error("data direction enable wrong");
    run_dark_a: assert property (
        STATE == FBSI_ST_INIT [*3] |-> !RUN_LED)
        else $error("run lamp lit in init");
    run_steady_a: assert property (
        STATE == FBSI_ST_OP [*4] |-> RUN_LED)
        else $error("run lamp dark in op");
    err_steady_a: assert property (
        ERR_IN.pdi_wdog [*4] |-> ERR_LED)
        else $error("error lamp dark on watchdog");
    link_dark_a: assert property (
        !LINK_PIN[0] [*6] |-> !LINK_LED[0])
        else $error("link lamp lit without link");
    cover property (RUN_LED && STATE == FBSI_ST_PREOP);
    cover property (RET_VALID && RET_READY);
    cover property ($rose(ERR_LED));
endmodule : fbsi_top_checker

bind fbsi_top fbsi_top_checker chk_u (.SYS_CLK, .RST, .RX_VALID, .RX_READY,
    .ADDR_HIT, .READ_STB, .TX_WORD, .TX_VALID, .TX_READY, .RET_VALID,
    .RET_READY, .CMD_CODE, .CMD_OK, .MBX_SERVICE, .MBX_OK, .DC_CYCLE_US,
    .DC_CYCLE_BAD, .SYNC_MODE, .STATE_REQ, .STATE_REQ_STB, .ERR_IN, .STATE,
    .OUT_PD_EN,
    .IN_PD_EN, .LINK_PIN, .ACT_PIN, .RUN_LED, .ERR_LED, .LINK_LED);

//--- testbench/tb.sv
// Self-checking bench of the slave status block.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
    n_checks++; \
    if ((gt) !== (ex)) begin \
        $display("wrong value %s exp %h got %h", nm, ex, gt); \
        err_count++; \
    end \
end
module tb;
    import fbsi_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    int err_count = 0;
    int n_checks = 0;
    fbsi_word_t rx_word, tx_word, ret_word, tm_w, rm_w, ew;
    logic rx_valid, rx_ready, tx_valid, tx_ready, ret_valid, ret_ready;
    logic addr_hit, ins_en, rd_stb, cmd_ok, mbx_ok, dc_bad, st_stb, err_clr;
    logic out_en, in_en, run_led, err_led, stall, tm_got, rm_got;
    logic [7:0] ins_data, rd_data, cmd;
    logic [3:0] mbx;
    logic [1:0] sm_role [4];
    logic [1:0] fmmu_role [3];
    logic [1:0] sync_req, sync_mode, link, act, link_led;
    logic [15:0] dc_us;
    fbsi_state_t st_req, st;
    fbsi_err_t err_in;
    fbsi_word_t q [$];
    int dcv [8] = '{0, 124, 125, 250, 7875, 8000, 8125, 8001};
    int e_n [4] = '{480, 640, 200, 100};
    int e_lo [4] = '{65, 145, 85, 94};
    int e_hi [4] = '{95, 175, 115, 100};

    always #4 clk = ~clk;

    fbsi_top #(.TICK_CYCLES_P(10)) dut_u (.SYS_CLK(clk), .RST(rst),
        .RX_WORD(rx_word), .RX_VALID(rx_valid), .RX_READY(rx_ready),
        .TX_WORD(tx_word), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .RET_WORD(ret_word), .RET_VALID(ret_valid), .RET_READY(ret_ready),
        .ADDR_HIT(addr_hit), .INSERT_DATA(ins_data), .INSERT_EN(ins_en),
        .READ_DATA(rd_data), .READ_STB(rd_stb), .CMD_CODE(cmd),
        .CMD_OK(cmd_ok), .MBX_SERVICE(mbx), .MBX_OK(mbx_ok),
        .SM_ROLE(sm_role), .FMMU_ROLE(fmmu_role), .SYNC_MODE_REQ(sync_req),
        .DC_CYCLE_US(dc_us), .SYNC_MODE(sync_mode), .DC_CYCLE_BAD(dc_bad),
        .STATE_REQ(st_req), .STATE_REQ_STB(st_stb), .ERR_IN(err_in),
        .ERR_CLEAR(err_clr), .STATE(st), .OUT_PD_EN(out_en),
        .IN_PD_EN(in_en), .LINK_PIN(link), .ACT_PIN(act),
        .RUN_LED(run_led), .ERR_LED(err_led), .LINK_LED(link_led));
    fbsi_master_model tm_u (.clk(clk), .valid(tx_valid), .word(tx_word),
        .stall(stall), .ready(tx_ready), .got(tm_got), .got_w(tm_w));
    fbsi_master_model rm_u (.clk(clk), .valid(ret_valid), .word(ret_word),
        .stall(stall), .ready(ret_ready), .got(rm_got), .got_w(rm_w));

    function automatic logic exp_cmd(input logic [7:0] c);
        return c inside {8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0a,
            8'h0b, 8'h0d, 8'h0e};
    endfunction : exp_cmd
    function automatic logic exp_bad(input logic [15:0] v);
        return !(v >= DC_STEP_US && v <= DC_MAX_US && v % DC_STEP_US == 0);
    endfunction : exp_bad

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    // Counts lit cycles; the window spans whole periods of the pattern.
    task automatic lamp(input string nm, input int p, input int n,
        input int lo, input int hi);
        logic [15:0] c;
        c = 16'h0;
        cyc(6);
        repeat (n) begin
            @(negedge clk);
            c += 16'(p == 0 ? run_led : p == 1 ? err_led : link_led[p - 2]);
        end
        `CHK(nm, 1'b1, c >= lo && c <= hi)
    endtask : lamp
    task automatic send(input int n);
        fbsi_word_t w;
        for (int i = 0; i < n; i++) begin
            w = fbsi_word_t'($urandom);
            rx_word = w;
            addr_hit = 1'($urandom);
            ins_en = 1'($urandom);
            ins_data = 8'($urandom);
            rx_valid = 1'b1;
            #1;
            for (int t = 0; !rx_ready && t < 300; t++) cyc(1);
            q.push_back({(addr_hit && ins_en) ? ins_data : w.data, w.last});
            cyc(1);
            `CHK("read_stb", addr_hit, rd_stb)
            if (addr_hit) `CHK("read_data", w.data, rd_data)
        end
        rx_valid = 1'b0;
    endtask : send
    task automatic drain;
        for (int t = 0; q.size() > 0 && t < 500; t++) cyc(1);
        `CHK("drained", 0, q.size())
    endtask : drain
    task automatic req(input fbsi_state_t s, input fbsi_err_t e);
        cyc(1);
        st_req = s;
        st_stb = 1'b1;
        err_in = e;
        cyc(1);
        st_stb = 1'b0;
        err_in = '0;
    endtask : req
    task automatic clear;
        cyc(1);
        err_clr = 1'b1;
        cyc(1);
        err_clr = 1'b0;
    endtask : clear

    always @(posedge clk) begin
        if (tm_got || rm_got) begin
            ew = q.size() > 0 ? q.pop_front() : '1;
            `CHK("out_word", ew, tm_got ? tm_w : rm_w)
            `CHK("path", link[1], tm_got)
        end
    end

    initial begin
        #400000;
        err_count++;
        stop_test;
    end

    initial begin
        {rx_word, rx_valid, addr_hit, ins_en, ins_data, cmd, mbx} = '0;
        {sync_req, dc_us, st_req, st_stb, err_in, err_clr, act} = '0;
        link = 2'b11;
        stall = 1'b0;
        void'($urandom(32'h5252));
        cyc(2);
        rst = 1'b0;
        `CHK("state", FBSI_ST_INIT, st)
        for (int i = 0; i < 256; i++) begin
            cyc(1);
            cmd = 8'(i);
            #1;
            `CHK("cmd_ok", exp_cmd(cmd), cmd_ok)
        end
        for (int i = 0; i < 16; i++) begin
            cyc(1);
            mbx = 4'(i);
            #1;
            `CHK("mbx_ok", i inside {1, 2, 3}, mbx_ok)
        end
        for (int i = 0; i < 4; i++) `CHK("sm", 2'(i), sm_role[i])
        for (int i = 0; i < 3; i++) `CHK("fmmu", 2'(i), fmmu_role[i])
        dc_us = 16'd1000;
        sync_req = 2'd1;
        cyc(2);
        for (int i = 0; i < 16; i++) begin
            cyc(1);
            dc_us = (i < 8) ? 16'(dcv[i]) : 16'($urandom_range(9000));
            #1;
            `CHK("dc_bad", exp_bad(dc_us), dc_bad)
        end
        sync_req = 2'd0;
        dc_us = 16'd100;
        cyc(2);
        sync_req = 2'd1;
        cyc(2);
        `CHK("dc_refuse", 2'd0, sync_mode)
        dc_us = 16'd1000;
        for (int m = 0; m < 4; m++) begin
            sync_req = 2'(m);
            cyc(2);
            `CHK("sync_mode", (m == 3) ? 2'd2 : 2'(m), sync_mode)
        end
        send(30);
        drain();
        stall = 1'b1;
        send(2);
        `CHK("rx_ready", 1'b0, rx_ready)
        stall = 1'b0;
        drain();
        link[1] = 1'b0;
        cyc(4);
        send(20);
        drain();
        link[1] = 1'b1;
        cyc(4);
        lamp("run_init", 0, 100, 0, 0);
        req(FBSI_ST_PREOP, '0);
        `CHK("state", FBSI_ST_PREOP, st)
        lamp("run_preop", 0, 320, 145, 175);
        req(FBSI_ST_SAFEOP, '0);
        lamp("run_safeop", 0, 480, 65, 95);
        req(FBSI_ST_OP, '0);
        lamp("run_op", 0, 100, 94, 100);
        req(FBSI_ST_INIT, 5'h10);
        `CHK("state", FBSI_ST_OP, st)
        lamp("err_blink", 1, 320, 145, 175);
        clear();
        lamp("err_off", 1, 100, 0, 0);
        for (int k = 0; k < 4; k++) begin
            cyc(1);
            err_in = fbsi_err_t'(5'h08 >> k);
            cyc(8);
            err_in = '0;
            if (k == 0) `CHK("state", FBSI_ST_SAFEOP, st)
            lamp("err_pat", 1, e_n[k], e_lo[k], e_hi[k]);
            clear();
        end
        for (int p = 0; p < 2; p++) begin
            link[p] = 1'b0;
            lamp("link_off", p + 2, 50, 0, 0);
            link[p] = 1'b1;
            lamp("link_on", p + 2, 50, 45, 50);
            act[p] = 1'b1;
            lamp("link_act", p + 2, 200, 85, 115);
            act[p] = 1'b0;
        end
        stop_test;
    end
endmodule : tb
